//--- logic/ivc_pkg.sv
// Constants, register map and types of the interrupt vector controller.
// Assumes an SFR port from the CPU core on the same clock (mclk).
// How it works
// - Taken interrupt loads PC with vector; vector jumps to flash at vector plus 4000h.
// - Vectors: reset 00, ext0 03, timer0 0B, ext1 13, timer1 1B, I2C 23, SPI 2B, extended 33.
// - Timer2, timer3, LF receiver, RF encoder share vector 33; software reads source flags.
// - Unmasked interrupt during idle leaves idle at once and goes to the vector.
// - Return from service re-enters idle when no resume event occurred meanwhile.
// - With a resume event, return continues after the idle-entering instruction.
// - Priority bit one means high; high may preempt a low service routine.
// - External request low-level triggered when edge-select is 0, falling edge when 1.
// - Edge mode sets request flag on high sample followed by low sample.
// - Ext0 on pin nine enabled by enable bit 0; ext1 on pin seven by bit 2.
// - Priority bits 6..0 mirror enable order; bit 7 reads zero; reset zero.
// - Timers 0 and 1 have own vectors; timers 2 and 3 go via extended group.
// - I2C vector when any I2C flag active and unmasked; polled in test modes.
// - SPI vector when any SPI flag active and unmasked.
// - In run mode LF wakeup flags and masks act as interrupt flags and masks.
// - RF encoder sources: buffer full status bit 0, shift empty status bit 1.
// - Extended flags: RF bit 3, LF bit 2, timer3 bit 1, timer2 bit 0; bits 3,2 clear on read.
package ivc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] IRQ_ENABLE_ADDR   = 8'hA8;
    localparam logic [7:0] IRQ_PRIORITY_ADDR = 8'hB8;
    localparam logic [7:0] EXT_FLAGS_ADDR    = 8'h8F;
    localparam logic [7:0] TIMER_CTRL_ADDR   = 8'h88;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam logic [7:0] PRIO_USED_MASK    = 8'h7F;
    localparam logic [7:0] EXT_FLAGS_MASK    = 8'h0F;

    // Enable and priority bit positions
    localparam int BIT_EXT0   = 0;
    localparam int BIT_TIMER0 = 1;
    localparam int BIT_EXT1   = 2;
    localparam int BIT_TIMER1 = 3;
    localparam int BIT_I2C    = 4;
    localparam int BIT_SPI    = 5;
    localparam int BIT_EXTGRP = 6;
    localparam int BIT_GLOBAL = 7;
    localparam int NUM_SRC    = 7;

    // Timer control bits for the external requests
    localparam int TC_EXT0_EDGE = 0;
    localparam int TC_EXT0_FLAG = 1;
    localparam int TC_EXT1_EDGE = 2;
    localparam int TC_EXT1_FLAG = 3;

    // Extended flag bit positions
    localparam int XF_TIMER2 = 0;
    localparam int XF_TIMER3 = 1;
    localparam int XF_LF     = 2;
    localparam int XF_RF     = 3;

    // Encoder status bits
    localparam int RFS_BUF_FULL   = 0;
    localparam int RFS_SHIFT_EMPT = 1;

    // ************************************************************
    // Vectors
    // ************************************************************
    localparam logic [15:0] FLASH_OFFSET = 16'h4000;
    localparam logic [7:0]  VEC_RESET    = 8'h00;
    localparam logic [7:0]  VEC_BASE     = 8'h03;
    localparam logic [7:0]  VEC_STEP     = 8'h08;

    typedef enum logic [3:0] {
        ST_RUN     = 4'b0001,
        ST_IDLE    = 4'b0010,
        ST_SERVICE = 4'b0100,
        ST_VECTOR  = 4'b1000
    } ivc_state_type;
endpackage

//--- logic/ivc_top.sv
// Interrupt vector controller: request capture, masking, two-level priority,
// vector generation and idle/resume interplay.
// Assumes the CPU core gives a one-cycle SFR port, a take strobe and a return strobe.
module ivc_top
    import ivc_pkg::*;
(
    input  wire logic        mclk,            // System clock, 40 MHz
    input  wire logic        reset,           // Async reset, active high
    input  wire logic [7:0]  sfr_addr,        // SFR address
    input  wire logic [7:0]  sfr_wdata,       // SFR write data
    input  wire logic        sfr_wr,          // SFR write strobe
    input  wire logic        sfr_rd,          // SFR read strobe
    output logic      [7:0]  sfr_rdata,       // SFR read data, registered
    input  wire logic        port_pin_nine,   // External request 0 pin
    input  wire logic        port_pin_seven,  // External request 1 pin
    input  wire logic        timer0_irq,      // Timer 0 overflow
    input  wire logic        timer1_irq,      // Timer 1 overflow
    input  wire logic        timer2_irq,      // Timer 2 request level
    input  wire logic        timer3_irq,      // Timer 3 request level
    input  wire logic [7:0]  i2c_flags,       // I2C flags, already masked in I2C
    input  wire logic        i2c_polled_mode, // Test/debug/programming mode
    input  wire logic [7:0]  spi_flags,       // SPI flags, already masked in SPI
    input  wire logic [7:0]  lf_wakeup_flags, // LF wakeup flags
    input  wire logic [7:0]  lf_wakeup_mask,  // LF wakeup masks, 1 enables
    input  wire logic [1:0]  encoder_status_reg, // Encoder full / shift empty
    input  wire logic        encoder_irq_mask,   // Encoder interrupt mask, 1 blocks
    input  wire logic        idle_request,    // Core asks to enter idle
    input  wire logic        resume_event,    // Resume event pulse
    input  wire logic        irq_taken,       // Core jumped to vector_pc
    input  wire logic        irq_return,      // Return from service executed
    output logic             irq_request,     // Vector pending for core
    output logic      [15:0] vector_pc,       // Flash-forwarded vector address
    output logic      [7:0]  vector_addr,     // Raw vector address
    output logic             cpu_idle,        // Core clock gated off
    output logic             resume_after_idle // Return goes past idle instruction
);
    function automatic logic [7:0] vec_of(input logic [2:0] src);
        vec_of = VEC_BASE + VEC_STEP * {5'h00, src};
    endfunction

    typedef struct packed {
        logic [1:0]    p9_sync;
        logic [1:0]    p7_sync;
        logic          p9_last;
        logic          p7_last;
        logic [7:0]    enable;
        logic [7:0]    priority_bits;
        logic [3:0]    timer_control_reg;
        logic [3:0]    xflags;
        logic [1:0]    active_lvl;   // bit1 high, bit0 low in service
        logic          resume_seen;
        logic          idle_return;
        ivc_state_type state;
        logic [7:0]    rdata;
        logic          req;
        logic [7:0]    vec;
        logic [15:0]   pc;
        logic [2:0]    cur_src;
        logic          resume_after;
    } ivc_regs_type;

    ivc_regs_type r_r;
    ivc_regs_type r_nxt;

    logic [NUM_SRC-1:0] pend;
    logic               lf_req;
    logic               rf_req;

    always_comb
    begin
        r_nxt  = r_r;
        lf_req = |(lf_wakeup_flags & lf_wakeup_mask);
        rf_req = ~encoder_irq_mask & |encoder_status_reg;

        // ************************************************************
        // External request capture
        // ************************************************************
        r_nxt.p9_sync = {r_r.p9_sync[0], port_pin_nine};
        r_nxt.p7_sync = {r_r.p7_sync[0], port_pin_seven};
        r_nxt.p9_last = r_r.p9_sync[1];
        r_nxt.p7_last = r_r.p7_sync[1];
        // Level mode mirrors the pin; the requester keeps it low until taken
        if (r_r.timer_control_reg[TC_EXT0_EDGE])
        begin
            if (r_r.p9_last && !r_r.p9_sync[1])
                r_nxt.timer_control_reg[TC_EXT0_FLAG] = 1'b1;
        end
        else
            r_nxt.timer_control_reg[TC_EXT0_FLAG] = ~r_r.p9_sync[1];
        if (r_r.timer_control_reg[TC_EXT1_EDGE])
        begin
            if (r_r.p7_last && !r_r.p7_sync[1])
                r_nxt.timer_control_reg[TC_EXT1_FLAG] = 1'b1;
        end
        else
            r_nxt.timer_control_reg[TC_EXT1_FLAG] = ~r_r.p7_sync[1];

        // ************************************************************
        // Extended source flags
        // ************************************************************
        // Read clears bits 3 and 2, but a new event in the same cycle wins
        if (sfr_rd && sfr_addr == EXT_FLAGS_ADDR)
        begin
            r_nxt.xflags[XF_RF] = 1'b0;
            r_nxt.xflags[XF_LF] = 1'b0;
        end
        if (rf_req)
            r_nxt.xflags[XF_RF] = 1'b1;
        if (lf_req)
            r_nxt.xflags[XF_LF] = 1'b1;
        r_nxt.xflags[XF_TIMER3] = timer3_irq;
        r_nxt.xflags[XF_TIMER2] = timer2_irq;

        // ************************************************************
        // Register access
        // ************************************************************
        r_nxt.rdata = REG_RESET;
        if (sfr_rd)
        begin
            if (sfr_addr == IRQ_ENABLE_ADDR)
                r_nxt.rdata = r_r.enable;
            else if (sfr_addr == IRQ_PRIORITY_ADDR)
                r_nxt.rdata = r_r.priority_bits & PRIO_USED_MASK;
            else if (sfr_addr == EXT_FLAGS_ADDR)
                r_nxt.rdata = {4'h0, r_r.xflags} & EXT_FLAGS_MASK;
            else if (sfr_addr == TIMER_CTRL_ADDR)
                r_nxt.rdata = {4'h0, r_r.timer_control_reg};
        end
        if (sfr_wr)
        begin
            if (sfr_addr == IRQ_ENABLE_ADDR)
                r_nxt.enable = sfr_wdata;
            else if (sfr_addr == IRQ_PRIORITY_ADDR)
                r_nxt.priority_bits = sfr_wdata & PRIO_USED_MASK;
            else if (sfr_addr == TIMER_CTRL_ADDR)
            begin
                r_nxt.timer_control_reg[TC_EXT0_EDGE] = sfr_wdata[TC_EXT0_EDGE];
                r_nxt.timer_control_reg[TC_EXT1_EDGE] = sfr_wdata[TC_EXT1_EDGE];
            end
        end

        // ************************************************************
        // Pending sources, masking
        // ************************************************************
        pend[BIT_EXT0]   = r_r.timer_control_reg[TC_EXT0_FLAG];
        pend[BIT_TIMER0] = timer0_irq;
        pend[BIT_EXT1]   = r_r.timer_control_reg[TC_EXT1_FLAG];
        pend[BIT_TIMER1] = timer1_irq;
        pend[BIT_I2C]    = |i2c_flags & ~i2c_polled_mode;
        pend[BIT_SPI]    = |spi_flags;
        pend[BIT_EXTGRP] = |r_r.xflags;
        pend = pend & r_r.enable[NUM_SRC-1:0]
             & {NUM_SRC{r_r.enable[BIT_GLOBAL]}};

        // ************************************************************
        // Priority resolution and sequencing
        // ************************************************************
        if (resume_event)
            r_nxt.resume_seen = 1'b1;
        r_nxt.req = 1'b0;
        begin
            logic [NUM_SRC-1:0] hi;
            logic [NUM_SRC-1:0] pick;
            logic               found;
            logic [2:0]         src;
            hi    = pend & r_r.priority_bits[NUM_SRC-1:0];
            pick  = (|hi) ? hi : pend;
            found = 1'b0;
            src   = 3'h0;
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (pick[i] && !found)
                begin
                    found = 1'b1;
                    src   = 3'(i);
                end
            end
            // Lower levels never nest inside same or higher; an offered vector is frozen until taken
            if (found && r_r.state != ST_VECTOR && !r_r.active_lvl[1]
                && !(r_r.active_lvl[0] && !(|hi)))
            begin
                r_nxt.req     = 1'b1;
                r_nxt.cur_src = src;
                r_nxt.vec     = vec_of(src);
                r_nxt.pc      = FLASH_OFFSET + {8'h00, vec_of(src)};
            end
        end

        case (r_r.state)
            ST_RUN:
            begin
                if (r_nxt.req)
                    r_nxt.state = ST_VECTOR;
                else if (idle_request)
                begin
                    r_nxt.state        = ST_IDLE;
                    r_nxt.resume_after = 1'b0;
                end
            end
            ST_IDLE:
            begin
                if (resume_event)
                begin
                    r_nxt.state        = ST_RUN;
                    r_nxt.resume_after = 1'b1;
                end
                else if (r_nxt.req)
                begin
                    r_nxt.state       = ST_VECTOR;
                    r_nxt.idle_return = 1'b1;
                    r_nxt.resume_seen = 1'b0;
                end
            end
            ST_VECTOR:
            begin
                r_nxt.req = 1'b1;
                if (irq_taken)
                begin
                    r_nxt.req   = 1'b0;
                    r_nxt.state = ST_SERVICE;
                    if (r_r.priority_bits[r_r.cur_src])
                        r_nxt.active_lvl[1] = 1'b1;
                    else
                        r_nxt.active_lvl[0] = 1'b1;
                end
            end
            ST_SERVICE:
            begin
                if (r_nxt.req)
                    r_nxt.state = ST_VECTOR;
                else if (irq_return)
                begin
                    if (r_r.active_lvl[1])
                        r_nxt.active_lvl[1] = 1'b0;
                    else
                        r_nxt.active_lvl[0] = 1'b0;
                    if (!(r_r.active_lvl[1] && r_r.active_lvl[0]))
                    begin
                        r_nxt.idle_return = 1'b0;
                        if (r_r.idle_return && !r_r.resume_seen && !resume_event)
                            r_nxt.state = ST_IDLE;
                        else
                        begin
                            r_nxt.state        = ST_RUN;
                            r_nxt.resume_after = r_r.idle_return;
                        end
                    end
                end
            end
            default:
                r_nxt.state = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r_r       <= '0;
            r_r.state <= ST_RUN;
            // Pins idle high; a zero here would fake a level request after reset
            r_r.p9_sync <= '1;
            r_r.p7_sync <= '1;
            r_r.p9_last <= '1;
            r_r.p7_last <= '1;
            r_r.vec   <= VEC_RESET;
            r_r.pc    <= FLASH_OFFSET;
        end
        else
            r_r <= r_nxt;
    end

    assign sfr_rdata         = r_r.rdata;
    assign irq_request       = r_r.req;
    assign vector_pc         = r_r.pc;
    assign vector_addr       = r_r.vec;
    assign cpu_idle          = r_r.state == ST_IDLE;
    assign resume_after_idle = r_r.resume_after;
endmodule

//--- testbench/ivc_monitor.sv
// Port checker of the interrupt vector controller.
// Assumes only ivc_top ports are seen; bound below to every ivc_top.
module ivc_monitor
    import ivc_pkg::*;
(
    input wire logic        mclk,            // System clock
    input wire logic        reset,           // Async reset
    input wire logic [7:0]  sfr_addr,        // SFR address
    input wire logic        sfr_rd,          // SFR read strobe
    input wire logic [7:0]  sfr_rdata,       // SFR read data
    input wire logic [7:0]  i2c_flags,       // I2C flags
    input wire logic        i2c_polled_mode, // I2C polled
    input wire logic        irq_taken,       // Vector taken
    input wire logic        irq_request,     // Vector pending
    input wire logic [15:0] vector_pc,       // Forwarded vector
    input wire logic [7:0]  vector_addr,     // Raw vector
    input wire logic        cpu_idle         // Core idle
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ************************************************************
    // Assertions
    // ************************************************************
    chk_vec_flash:
        assert property (irq_request |-> vector_pc == FLASH_OFFSET + {8'h00, vector_addr})
            else $error("vector not forwarded into flash");
    chk_vec_table:
        assert property (irq_request |-> vector_addr inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33})
            else $error("vector outside the table");
    chk_req_stand:
        assert property (irq_request && !irq_taken |=> irq_request && $stable(vector_addr))
            else $error("pending vector dropped or changed");
    chk_take_drop:
        assert property (irq_request && irq_taken |=> !irq_request)
            else $error("request stays after take");
    chk_svc_awake:
        assert property (irq_taken |=> !cpu_idle)
            else $error("core idle during service");
    chk_rd_quiet:
        assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
            else $error("read data without a read");
    chk_prio_top:
        assert property (sfr_rd && sfr_addr == IRQ_PRIORITY_ADDR |=> !sfr_rdata[7])
            else $error("priority bit 7 not zero");
    chk_i2c_cause:
        assert property ($rose(irq_request) && vector_addr == 8'h23 |-> $past(i2c_flags) != 8'h00
                         && !$past(i2c_polled_mode))
            else $error("I2C vector without unmasked flag");
    cover property (irq_request && irq_taken);
    cover property (cpu_idle ##1 !cpu_idle);
    cover property (sfr_rd ##1 sfr_rdata != 8'h00);
endmodule

bind ivc_top ivc_monitor u_mon (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .i2c_flags(i2c_flags), .i2c_polled_mode(i2c_polled_mode),
    .irq_taken(irq_taken), .irq_request(irq_request), .vector_pc(vector_pc),
    .vector_addr(vector_addr), .cpu_idle(cpu_idle));

//--- testbench/ivc_cpu_model.sv
// CPU core model: takes pending vectors, returns from service on command.
// Assumes ivc_top outputs on mclk; strobes change 1 ns after the edge.
module ivc_cpu_model
(
    input  wire logic       mclk,        // System clock
    input  wire logic       reset,       // Async reset
    input  wire logic       irq_request, // Vector pending
    input  wire logic       ret_go,      // Bench asks for a return
    input  wire logic [3:0] take_lag,    // Slow take, extra cycles
    output logic            irq_taken,   // Take strobe
    output logic            irq_return   // Return strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    int depth = 0;
    int lag = 0;
    bit take;
    bit back;
    always @(posedge mclk or posedge reset)
    begin
        take = !reset && irq_request && !irq_taken && lag >= int'(take_lag);
        back = !reset && !take && ret_go && depth > 0 && !irq_return;
        // Return only once per taken vector, never in the same cycle as a take
        irq_taken <= #1 take;
        irq_return <= #1 back;
        depth <= reset ? 0 : depth + int'(take) - int'(back);
        lag <= (reset || take || !irq_request) ? 0 : lag + 1;
    end
endmodule

//--- testbench/tb_interrupt_vector_controller.sv
// Self-checking bench of ivc_top against an integer model of enables and priorities.
// Assumes ivc_monitor is bound by its own file and the CPU core model answers.
module tb_interrupt_vector_controller
    import ivc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, pin9 = 1'b1, pin7 = 1'b1;
    logic       t0 = 1'b0, t1 = 1'b0, t2 = 1'b0, t3 = 1'b0, polled = 1'b0, idle_go = 1'b0, res_ev = 1'b0;
    logic       ret_go = 1'b0, irq_taken, irq_return, irq_request, cpu_idle, resume_after_idle;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, i2c = 8'h00, spi = 8'h00, lf = 8'h00, sfr_rdata;
    logic [7:0] lf_mask = 8'h24, vector_addr, exp_q[$];
    logic [1:0] enc = 2'b00;
    logic [3:0] take_lag = 4'h0;
    logic [15:0] vector_pc;
    logic [7:0] regs[5] = '{IRQ_ENABLE_ADDR, IRQ_PRIORITY_ADDR, EXT_FLAGS_ADDR, TIMER_CTRL_ADDR, 8'h55};
    int         error_cnt = 0, check_count = 0, ie_m, ip_m, n;
    always #12.5 mclk = ~mclk;
    ivc_top dut (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .port_pin_nine(pin9), .port_pin_seven(pin7),
        .timer0_irq(t0), .timer1_irq(t1), .timer2_irq(t2), .timer3_irq(t3), .i2c_flags(i2c),
        .i2c_polled_mode(polled), .spi_flags(spi), .lf_wakeup_flags(lf), .lf_wakeup_mask(lf_mask),
        .encoder_status_reg(enc), .encoder_irq_mask(1'b0), .idle_request(idle_go), .resume_event(res_ev),
        .irq_taken(irq_taken), .irq_return(irq_return), .irq_request(irq_request), .vector_pc(vector_pc),
        .vector_addr(vector_addr), .cpu_idle(cpu_idle), .resume_after_idle(resume_after_idle));
    ivc_cpu_model u_cpu (.mclk(mclk), .reset(reset), .irq_request(irq_request), .ret_go(ret_go),
        .take_lag(take_lag), .irq_taken(irq_taken), .irq_return(irq_return));
    // ************************************************************
    // Model and tasks
    // ************************************************************
    function automatic int exp_vec(input int pend);
        for (int h = 1; h >= 0; h--)
            for (int i = 0; i < NUM_SRC; i++)
                if (pend[i] && ie_m[i] && ie_m[BIT_GLOBAL] && ip_m[i] == h)
                    return 3 + 8 * i;
        return 0;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick;
        @(posedge mclk);
        #2;
    endtask
    task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick;
        sfr_wr = 1'b0;
        tick;
    endtask
    task automatic sfr_get(input logic [7:0] a, input logic [7:0] exp, input string msg);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick;
        sfr_rd = 1'b0;
        check({8'h00, sfr_rdata}, {8'h00, exp}, msg);
        tick;
    endtask
    task automatic set_regs(input int ie, input int ip);
        ie_m = ie;
        ip_m = ip;
        sfr_put(IRQ_ENABLE_ADDR, 8'(ie));
        sfr_put(IRQ_PRIORITY_ADDR, 8'(ip));
    endtask
    task automatic wait_req(input int v);
        exp_q.push_back(8'(v));
        for (n = 0; n < 20 && irq_request !== 1'b1; n++)
            tick;
        check(irq_request, 1'b1, "no request");
    endtask
    task automatic wait_take;
        for (n = 0; n < 20 && irq_request !== 1'b0; n++)
            tick;
    endtask
    task automatic ret;
        repeat (4) tick;
        ret_go = 1'b1;
        tick;
        ret_go = 1'b0;
        repeat (3) tick;
    endtask
    task automatic quiet(input string msg);
        logic q;
        q = 1'b0;
        repeat (8)
        begin
            tick;
            q = q | irq_request;
        end
        check(q, 1'b0, msg);
    endtask
    task automatic fire(input int s, input bit on);
        case (s)
            0: pin9 = !on;
            1: t0 = on;
            2: pin7 = !on;
            3: t1 = on;
            4: i2c = on ? 8'($urandom_range(255, 1)) : 8'h00;
            5: spi = on ? 8'($urandom_range(255, 1)) : 8'h00;
            6: t2 = on;
            7: t3 = on;
            8: lf = on ? 8'h20 : 8'hDB; // flags outside the mask must not request
            9: enc = {1'b0, on};
            default: enc = {on, 1'b0};
        endcase
    endtask
    task automatic service(input int s, input bit res);
        int xb;
        xb = s < 9 ? s - 6 : 3;
        fire(s, 1'b1);
        wait_req(exp_vec(1 << (s < 6 ? s : 6)));
        if (s >= 6)
            sfr_get(EXT_FLAGS_ADDR, 8'(1 << xb), "group flag");
        wait_take;
        fire(s, 1'b0);
        res_ev = res;
        tick;
        res_ev = 1'b0;
        // Handler reads the group flags before returning, else a sticky bit requests again
        if (s >= 6)
        begin
            sfr_get(EXT_FLAGS_ADDR, xb >= 2 ? 8'(1 << xb) : 8'h00, "sticky flag");
            sfr_get(EXT_FLAGS_ADDR, 8'h00, "flag cleared by read");
        end
        ret;
    endtask
    always @(posedge mclk)
        if (!reset && irq_taken && irq_request && exp_q.size() > 0)
        begin
            check(vector_pc, FLASH_OFFSET + 16'(exp_q[0]), "forwarded vector");
            check(vector_addr, exp_q.pop_front(), "vector address");
        end
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end
    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        void'($urandom(32'h79AF6DFC));
        repeat (6) @(posedge mclk);
        #2 reset = 1'b0;
        sfr_put(8'h55, 8'hFF);
        foreach (regs[i])
            sfr_get(regs[i], 8'h00, "reset or unmapped value");
        sfr_put(IRQ_PRIORITY_ADDR, 8'hFF);
        sfr_get(IRQ_PRIORITY_ADDR, PRIO_USED_MASK, "priority bit 7");
        $display("test registers finished");
        for (int s = 0; s < 11; s++)
        begin
            set_regs(32'h80 | (1 << (s < 6 ? s : 6)), $urandom_range(127, 0));
            sfr_get(IRQ_ENABLE_ADDR, 8'(ie_m), "enable readback");
            take_lag = 4'($urandom_range(3, 0));
            service(s, 1'b0);
        end
        $display("test vectors finished");
        set_regs(32'h12, 0);
        fire(1, 1'b1);
        quiet("global enable off");
        fire(1, 1'b0);
        set_regs(32'h90, 0);
        polled = 1'b1;
        fire(4, 1'b1);
        quiet("polled I2C");
        fire(4, 1'b0);
        polled = 1'b0;
        $display("test masking finished");
        set_regs(32'h8A, 32'h08);
        fire(1, 1'b1);
        fire(3, 1'b1);
        wait_req(exp_vec(32'h0A));
        wait_take;
        fire(3, 1'b0);
        quiet("low under high");
        ret;
        wait_req(exp_vec(32'h02));
        wait_take;
        fire(3, 1'b1);
        wait_req(exp_vec(32'h08));
        wait_take;
        fire(3, 1'b0);
        fire(1, 1'b0);
        ret;
        ret;
        $display("test priority finished");
        set_regs(32'h82, 0);
        for (int r = 0; r < 2; r++)
        begin
            idle_go = 1'b1;
            tick;
            idle_go = 1'b0;
            for (n = 0; n < 10 && cpu_idle !== 1'b1; n++)
                tick;
            check(cpu_idle, 1'b1, "idle entry");
            service(1, r[0]);
            check(cpu_idle, !r[0], "idle after return");
            check(resume_after_idle, r[0], "resume past idle");
        end
        $display("test idle finished");
        sfr_put(TIMER_CTRL_ADDR, 8'h01);
        set_regs(32'h81, 0);
        pin9 = 1'b0;
        repeat (2) tick;
        pin9 = 1'b1;
        wait_req(exp_vec(1));
        sfr_get(TIMER_CTRL_ADDR, 8'h03, "edge flag");
        $display("test edge finished");
        wrap_up;
    end
endmodule
